// File: src/fsc_top.sv
// I2C command interpreter and measurement readout of a flow sensor.
// Assumes raw flow, temperature and averaging state from a front end.
// Overview of operation
// R1: Each command word is sixteen bits.
// R2: Argument commands carry a sixteen-bit argument plus eight-bit checksum.
// R3: Read data is sixteen-bit words, each followed by a checksum byte.
// R4: Host NACK plus stop ends a transfer; device releases data line.
// R5: Start codes select oxygen, air, or mixture with per-mille argument.
// R6: Results refresh continuously; each read header returns all three.
// R7: Host sends no other command while measuring, until stop.
// R8: First result becomes available 12 ms after start.
// R9: Read header without data gets a NACK on the address.
// R10: Read gives flow, crc, temperature, crc, status, crc bytes.
// R11: Host may stop reading after flow word and its checksum.
// R12: Flow and temperature are raw sixteen-bit signed values.
// R13: Status bits 15:12 encode the running start command.
// R14: Status bit 11 shows exponential smoothing active.
// R15: Status bit 10 shows fixed-count averaging active.
// R16: Status bits 9:0 are 0x3FF for pure gas, else per mille.
// R17: Device answers at seven-bit address 0x29.
// R18: Results update about every 0.5 ms while measuring.
// R19: Stop code 0x3FF9 idles the sensor; busy up to 0.5 ms.
// R20: CRC-8 over each word with parameter polynomial and seed.
// R21: Words travel most significant byte and bit first.
`timescale 1ns/1ps
`default_nettype none

module fsc_top
  import fsc_pkg::*;
#(
  parameter logic [7:0] CRC_POLY = FSC_CRC_POLY,
  parameter logic [7:0] CRC_INIT = FSC_CRC_INIT,
  parameter int FIRST_CYC = FSC_FIRST_RESULT_CYC,
  parameter int PERIOD_CYC = FSC_MEAS_PERIOD_CYC,
  parameter int BUSY_CYC = FSC_STOP_BUSY_CYC
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // I2C pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  // Front end results
  input wire logic [15:0] FLOW_RAW,
  input wire logic [15:0] TEMP_RAW,
  input wire logic EXP_SMOOTH,
  input wire logic FIXED_AVG,
  // Status
  output logic MEASURING,
  output logic DATA_VALID,
  output logic [15:0] STATUS_WORD
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic scl_q;
  logic sda_q;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s <= {scl_s[1:0], SCL_IN};
      sda_s <= {sda_s[1:0], SDA_IN};
      if (scl_s[1] == scl_s[2]) scl_q <= scl_s[2];
      if (sda_s[1] == sda_s[2]) sda_q <= sda_s[2];
    end
  end
  wire scl_rise = (scl_s[1] & scl_s[2]) & ~scl_q;
  wire scl_fall = ~(scl_s[1] | scl_s[2]) & scl_q;
  wire sda_now = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_q;
  wire start_c = scl_q & (scl_s[1] & scl_s[2]) & sda_q & ~sda_now;
  wire stop_c = scl_q & (scl_s[1] & scl_s[2]) & ~sda_q & sda_now;

  // ****************************************
  // CRC-8 function
  // ****************************************
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin // R20
      c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // ****************************************
  // Measurement control
  // ****************************************
  logic meas;
  logic valid;
  logic [3:0] cmd_id;
  logic [9:0] conc;
  logic [23:0] timer;
  logic [15:0] flow_l;
  logic [15:0] temp_l;
  logic [15:0] stat_l;
  logic [23:0] busy;
  wire [15:0] status_now = {cmd_id, EXP_SMOOTH, FIXED_AVG, conc}; // R13 R14 R15

  // Link state
  fsc_state_t state;
  logic [3:0] bitn;
  logic [7:0] shreg;
  logic rw;
  logic [3:0] wbyte;
  logic [39:0] wbuf;
  logic [3:0] rbyte;
  logic [71:0] rframe;
  logic cmd_go;

  // Command sits at the top of a five-byte write, else in the low word
  wire [15:0] cmd_w = (wbyte == 4'h5) ? wbuf[39:24] : wbuf[15:0];
  wire is_start = (cmd_w == FSC_CMD_START_O2) | (cmd_w == FSC_CMD_START_AIR);
  wire is_mix = (cmd_w == FSC_CMD_START_MIX);
  wire arg_ok = (crc8(wbuf[23:8]) == wbuf[7:0]); // R2
  wire [3:0] new_id = (cmd_w == FSC_CMD_START_O2) ? FSC_ID_O2 :
    (cmd_w == FSC_CMD_START_AIR) ? FSC_ID_AIR : FSC_ID_MIX;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      meas <= 1'b0;
      valid <= 1'b0;
      cmd_id <= 4'h0;
      conc <= FSC_CONC_PURE;
      timer <= 24'h000000;
      busy <= 24'h000000;
      flow_l <= 16'h0000;
      temp_l <= 16'h0000;
      stat_l <= 16'h0000;
    end else begin
      if (busy != 24'h000000) busy <= busy - 24'h000001;
      if (cmd_go && busy == 24'h000000 && wbyte == 4'h2 && is_start) begin
        meas <= 1'b1; // R5
        valid <= 1'b0;
        cmd_id <= new_id; // R13
        conc <= FSC_CONC_PURE; // R16
        timer <= 24'(FIRST_CYC - 1); // R8
      end else if (cmd_go && busy == 24'h000000 && wbyte == 4'h5 && is_mix
                   && arg_ok) begin
        meas <= 1'b1; // R5
        valid <= 1'b0;
        cmd_id <= new_id;
        conc <= wbuf[17:8]; // R16
        timer <= 24'(FIRST_CYC - 1);
      end else if (cmd_go && wbyte == 4'h2 && cmd_w == FSC_CMD_STOP) begin
        meas <= 1'b0; // R19
        valid <= 1'b0;
        busy <= 24'(BUSY_CYC);
      end else if (meas) begin
        if (timer == 24'h000000) begin
          timer <= 24'(PERIOD_CYC - 1); // R18
          valid <= 1'b1; // R8
          flow_l <= FLOW_RAW; // R12
          temp_l <= TEMP_RAW; // R12
          stat_l <= status_now;
        end else begin
          timer <= timer - 24'h000001;
        end
      end
    end
  end

  // ****************************************
  // I2C slave engine
  // ****************************************
  wire addr_hit = (shreg[7:1] == FSC_I2C_ADDR); // R17
  wire [7:0] tx_byte = rframe[71:64];

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state <= FSC_IDLE;
      bitn <= 4'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      wbyte <= 4'h0;
      wbuf <= 40'h0000000000;
      rbyte <= 4'h0;
      rframe <= 72'h0;
      cmd_go <= 1'b0;
      SDA_OUT <= 1'b1;
      SDA_OE_N <= 1'b1;
    end else begin
      cmd_go <= 1'b0;
      if (stop_c) begin
        state <= FSC_IDLE; // R4
        SDA_OE_N <= 1'b1;
        cmd_go <= (state != FSC_IDLE) & ~rw & (wbyte != 4'h0);
      end else if (start_c) begin
        cmd_go <= (state != FSC_IDLE) & ~rw & (wbyte != 4'h0);
        state <= FSC_ADDR;
        bitn <= 4'h0;
        wbyte <= 4'h0;
        SDA_OE_N <= 1'b1;
      end else begin
        case (state)
          FSC_ADDR, FSC_WRX: begin
            if (scl_rise) begin
              // Same latency as the clock edge; sda_q lags one cycle
              shreg <= {shreg[6:0], sda_now}; // R21
              bitn <= bitn + 4'h1;
            end else if (scl_fall && bitn == 4'h8) begin
              bitn <= 4'h0;
              if (state == FSC_ADDR) begin
                rw <= shreg[0];
                if (addr_hit && !(shreg[0] && !valid)) begin
                  SDA_OUT <= 1'b0;
                  SDA_OE_N <= 1'b0;
                  state <= FSC_ACK;
                end else begin
                  state <= FSC_IDLE; // R9
                end
                rframe <= {flow_l, crc8(flow_l), temp_l, crc8(temp_l),
                           stat_l, crc8(stat_l)}; // R10 R3
                rbyte <= 4'h0;
              end else begin
                if (wbyte < 4'h5) begin
                  wbuf <= {wbuf[31:0], shreg}; // R1 R21
                  wbyte <= wbyte + 4'h1;
                end
                SDA_OUT <= 1'b0;
                SDA_OE_N <= 1'b0;
                state <= FSC_ACK;
              end
            end
          end
          FSC_ACK: begin
            if (scl_fall) begin
              if (rw) begin
                SDA_OUT <= tx_byte[7]; // R6
                SDA_OE_N <= 1'b0;
                bitn <= 4'h1;
                state <= FSC_RTX;
              end else begin
                SDA_OE_N <= 1'b1;
                state <= FSC_WRX;
              end
            end
          end
          FSC_RTX: begin
            if (scl_fall) begin
              if (bitn == 4'h8) begin
                SDA_OE_N <= 1'b1;
                bitn <= 4'h0;
                state <= FSC_RACK;
              end else begin
                SDA_OUT <= tx_byte[3'(7 - bitn)];
                bitn <= bitn + 4'h1;
              end
            end
          end
          FSC_RACK: begin
            if (scl_rise) begin
              rframe <= {rframe[63:0], 8'hFF}; // R11
              rbyte <= rbyte + 4'h1;
              state <= sda_now ? FSC_SKIP : FSC_ACK; // R4
            end
          end
          FSC_SKIP: SDA_OE_N <= 1'b1; // R4
          FSC_IDLE: SDA_OE_N <= 1'b1;
          default: state <= FSC_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Status outputs
  // ****************************************
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      MEASURING <= 1'b0;
      DATA_VALID <= 1'b0;
      STATUS_WORD <= 16'h0000;
    end else begin
      MEASURING <= meas;
      DATA_VALID <= valid;
      STATUS_WORD <= stat_l;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_nack_nodata: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (state == FSC_ADDR && scl_fall && bitn == 4'h8 && shreg[0] && !valid)
    |=> state == FSC_IDLE && SDA_OE_N) // R9
    else $error("read without data was acknowledged");
  a_stop_release: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    stop_c |=> SDA_OE_N && state == FSC_IDLE) // R4
    else $error("data line held after stop");
  a_first_delay: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    ($rose(meas)) |-> !valid [*8]) // R8
    else $error("result valid too soon after start");
  a_stop_idles: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (cmd_go && wbyte == 4'h2 && cmd_w == FSC_CMD_STOP) |=> !meas && !valid)
    // R19
    else $error("stop did not idle sensor");
  a_pure_conc: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (meas && cmd_id != FSC_ID_MIX) |-> conc == FSC_CONC_PURE) // R16
    else $error("pure gas concentration wrong");
  a_mix_id: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (cmd_go && busy == 24'h000000 && wbyte == 4'h5 && is_mix && arg_ok)
    |=> cmd_id == FSC_ID_MIX && meas) // R13 R5
    else $error("mixture start not recorded");
  a_refresh: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (meas && timer == 24'h000000 && !cmd_go) |=> valid && flow_l ==
    $past(FLOW_RAW) && timer == 24'(PERIOD_CYC - 1)) // R18 R6
    else $error("results not refreshed");
  a_frame_crc: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (state == FSC_ACK && rw && rbyte == 4'h0)
    |-> rframe[55:48] == crc8(rframe[71:56])) // R3 R20
    else $error("flow checksum wrong");

endmodule // fsc_top

`default_nettype wire

// File: src/fsc_pkg.sv
// Constants for the flow sensor I2C command and readout block.
// Assumes a 10 MHz system clock and an I2C link sampled from pins.
package fsc_pkg;

  // ****************************************
  // Link and timing
  // ****************************************
  localparam logic [6:0] FSC_I2C_ADDR = 7'h29;
  localparam int FSC_CLK_HZ = 10000000;
  localparam int FSC_FIRST_RESULT_US = 12000;
  localparam int FSC_MEAS_PERIOD_NS = 500000;
  localparam int FSC_STOP_BUSY_NS = 500000;
  localparam int FSC_FIRST_RESULT_CYC =
    (FSC_FIRST_RESULT_US * (FSC_CLK_HZ / 1000000));
  localparam int FSC_MEAS_PERIOD_CYC =
    FSC_MEAS_PERIOD_NS / (1000000000 / FSC_CLK_HZ);
  localparam int FSC_STOP_BUSY_CYC =
    FSC_STOP_BUSY_NS / (1000000000 / FSC_CLK_HZ);

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [15:0] FSC_CMD_START_O2 = 16'h3603;
  localparam logic [15:0] FSC_CMD_START_AIR = 16'h3608;
  localparam logic [15:0] FSC_CMD_START_MIX = 16'h3632;
  localparam logic [15:0] FSC_CMD_STOP = 16'h3FF9;

  // ****************************************
  // Status word layout
  // ****************************************
  localparam int FSC_ST_CMD_LSB = 12;
  localparam int FSC_ST_EXP_BIT = 11;
  localparam int FSC_ST_AVG_BIT = 10;
  localparam logic [9:0] FSC_CONC_PURE = 10'h3FF;
  localparam logic [3:0] FSC_ID_O2 = 4'h0;
  localparam logic [3:0] FSC_ID_AIR = 4'h1;
  localparam logic [3:0] FSC_ID_MIX = 4'h6;

  // ****************************************
  // Checksum defaults
  // ****************************************
  localparam logic [7:0] FSC_CRC_POLY = 8'h31;
  localparam logic [7:0] FSC_CRC_INIT = 8'hFF;

  typedef enum logic [2:0] {
    FSC_IDLE = 3'b000,
    FSC_ADDR = 3'b001,
    FSC_ACK = 3'b010,
    FSC_WRX = 3'b011,
    FSC_RTX = 3'b100,
    FSC_RACK = 3'b101,
    FSC_SKIP = 3'b110
  } fsc_state_t;

endpackage

// File: bench/fsc_host.sv
// I2C host model that drives the flow sensor link bit by bit.
// Assumes the bench resolves SDA with a pull-up from both enables.
`timescale 1ns/1ps
`default_nettype none

module fsc_host (
  // I2C lines
  output logic scl,
  output logic sda_low,
  input wire logic sda,
  // Observed unit per byte
  output logic res_stb,
  output logic [7:0] res
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    res_stb = 1'b0;
    res = 8'h00;
  end

  // One SCL period; SCL stands high between frames
  task automatic bit_x(input logic b, output logic r);
    sda_low = !b;
    #200 scl = 1'b1;
    #200 r = sda;
    #200 scl = 1'b0;
    #200;
  endtask

  task automatic start();
    sda_low = 1'b1;
    #400 scl = 1'b0;
    #200;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #200 scl = 1'b1;
    #400 sda_low = 1'b0;
    #400;
  endtask

  task automatic emit(input logic [7:0] v);
    res = v;
    res_stb = 1'b1;
    // Strobe takes no time from the link, so bits stay on the grid
    res_stb <= #10 1'b0;
  endtask

  task automatic wr(input logic [7:0] b);
    logic a;
    for (int i = 7; i >= 0; i--) bit_x(b[i], a);
    bit_x(1'b1, a);
    emit({7'h00, a});
  endtask

  task automatic rd(input logic last);
    logic [7:0] d;
    logic a;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, a);
    emit(d);
  endtask
endmodule // fsc_host

`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the flow sensor command and readout block.
// Assumes the host model fsc_host and the package fsc_pkg.
`timescale 1ns/1ps
`default_nettype none

module tb import fsc_pkg::*;;
  localparam int FC = 200;
  localparam int PC = 50;
  localparam int BC = 20;
  localparam logic [7:0] POLY = 8'h1D;
  localparam logic [7:0] INIT = 8'hA5;
  logic clk_sys, rst_n, scl, sda_low, sda, sda_out, sda_oe_n, res_stb;
  logic exp_sm, fix_avg, meas, dval;
  logic [7:0] res;
  logic [15:0] flow, temp, status;
  logic [7:0] q[$];
  int err_count = 0;
  int n_checks = 0;
  integer seed = 32'hB2613BAA;

  assign sda = !(sda_low || (!sda_oe_n && !sda_out));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  fsc_top #(.CRC_POLY(POLY), .CRC_INIT(INIT), .FIRST_CYC(FC),
    .PERIOD_CYC(PC), .BUSY_CYC(BC)) dut_u (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .FLOW_RAW(flow),
    .TEMP_RAW(temp), .EXP_SMOOTH(exp_sm), .FIXED_AVG(fix_avg),
    .MEASURING(meas), .DATA_VALID(dval), .STATUS_WORD(status));

  fsc_host host_u (.scl(scl), .sda_low(sda_low), .sda(sda),
    .res_stb(res_stb), .res(res));

  // ****************************************
  // Checking
  // ****************************************
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = INIT;
    for (int i = 15; i >= 0; i--)
      c = (c[7] ^ w[i]) ? ((c << 1) ^ POLY) : (c << 1);
    return c;
  endfunction

  task automatic finish_test();
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic bad(input string m);
    err_count++;
    $display("BAD %0t %s", $time, m);
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) bad($sformatf("port %h exp %h", g, e));
  endtask

  task automatic cmp_byte(input logic [7:0] e);
    n_checks++;
    if (res !== e) bad($sformatf("byte %h exp %h", res, e));
  endtask

  always @(posedge res_stb) begin
    if (q.size() == 0) bad("extra byte");
    else cmp_byte(q.pop_front());
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    bad("timeout");
    finish_test();
  end

  // ****************************************
  // Stimulus
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic w(input logic [7:0] b, input logic [7:0] e);
    q.push_back(e);
    host_u.wr(b);
  endtask

  task automatic cmd(input logic [15:0] c, input logic a_en,
    input logic [15:0] a);
    host_u.start();
    w(8'h52, 8'h00);
    w(c[15:8], 8'h00);
    w(c[7:0], 8'h00);
    if (a_en) begin
      w(a[15:8], 8'h00);
      w(a[7:0], 8'h00);
      w(crc8(a), 8'h00);
    end
    host_u.stop();
  endtask

  task automatic nodata(input logic [7:0] a);
    host_u.start();
    w(a, 8'h01);
    host_u.stop();
  endtask

  task automatic rdm(input int n, input logic [15:0] s);
    logic [71:0] v;
    v = {flow, crc8(flow), temp, crc8(temp), s, crc8(s)};
    host_u.start();
    w(8'h53, 8'h00);
    for (int k = 0; k < n; k++) begin
      q.push_back(v[71 - 8 * k -: 8]);
      host_u.rd(k == n - 1);
    end
    host_u.stop();
  endtask

  initial begin
    logic [15:0] codes [4];
    logic [3:0] ids [4];
    logic [15:0] arg;
    logic [15:0] st;
    rst_n = 1'b0;
    flow = 16'h0000;
    temp = 16'h0000;
    exp_sm = 1'b0;
    fix_avg = 1'b0;
    codes = '{FSC_CMD_START_O2, FSC_CMD_START_AIR, FSC_CMD_START_MIX,
      16'h3615};
    ids = '{FSC_ID_O2, FSC_ID_AIR, FSC_ID_MIX, 4'h2};
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys) rst_n = 1'b1;
    cyc(6);
    chk({meas, dval, sda_oe_n, 13'h0}, 16'h2000);
    chk(status, 16'h0000);
    nodata(8'h53);
    nodata(8'h54);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys);
      flow = 16'($random(seed));
      temp = 16'($random(seed));
      {exp_sm, fix_avg} = 2'($random(seed));
      arg = 16'({$random(seed)} % 1001);
      st = {ids[i], exp_sm, fix_avg, (i == 2) ? arg[9:0] : FSC_CONC_PURE};
      cmd(codes[i], i == 2, arg);
      cyc(4);
      chk({15'h0, meas}, {15'h0, i != 3});
      if (i < 3) begin
        nodata(8'h53);
        cyc(FC + 2 * PC);
        chk({15'h0, dval}, 16'h0001);
        chk(status, st);
        rdm(9, st);
        @(negedge clk_sys) flow = ~flow;
        cyc(2 * PC);
        rdm(3, st);
        cmd(FSC_CMD_STOP, 1'b0, 16'h0000);
        cyc(4);
        chk({15'h0, meas}, 16'h0000);
        cyc(BC);
      end
    end
    cyc(10);
    if (q.size() != 0) bad("missing byte");
    finish_test();
  end
endmodule // tb

`default_nettype wire
